/* File: src/edc_cfg.svh */
// Purpose: constants for the extended/decimal/integer operand classifier
// Assumes: included by bare name from the package only
// Notes: field positions follow the in-memory container layout
`ifndef EDC_CFG_SVH
`define EDC_CFG_SVH

`define EDC_CONT_W 96
`define EDC_EXT_W 80
`define EDC_EXT_FRAC_MSB 62
`define EDC_EXT_J_BIT 63
`define EDC_EXT_EXP_LSB 64
`define EDC_EXT_EXP_MSB 78
`define EDC_EXT_SIGN_BIT 79
`define EDC_EXT_EXP_W 15
`define EDC_EXT_BIAS 15'h3fff
`define EDC_DEC_W 76
`define EDC_DEC_DIGITS 18
`define EDC_DEC_SIGN_MSB 3
`define EDC_DEC_DIG_LSB 4
`define EDC_INT_W 32

`endif

/* File: src/edc_pkg.sv */
// Purpose: types shared by the operand classifier
// Assumes: edc_cfg.svh holds the numeric constants
// Notes: the class vector is one-hot, all zero for the reserved format, bit order follows the enum below
package edc_pkg;
	`include "edc_cfg.svh"

	typedef enum logic [1:0] {
		EDC_FMT_EXT,
		EDC_FMT_DEC,
		EDC_FMT_INT,
		EDC_FMT_RSV
	} edc_fmt_t;

	// one-hot class bit positions
	typedef enum int {
		EDC_C_NORM,
		EDC_C_UNNORM,
		EDC_C_DENORM,
		EDC_C_ZERO,
		EDC_C_INF,
		EDC_C_QNAN,
		EDC_C_SNAN,
		EDC_C_NUM
	} edc_cls_idx_t;

	typedef logic [7:0] edc_cls_t;
endpackage

/* File: src/edc_dec_digit_chk.sv */
// Purpose: flags any bcd digit of a decimal operand holding 10 or more
// Assumes: digits sit above the 4-bit sign code, lowest digit first
// Notes: purely combinational
`timescale 1ns/1ps
module edc_dec_digit_chk #(
	parameter int NDIG = `EDC_DEC_DIGITS
) (
	input wire logic [4*NDIG-1:0] bcd_digit_fields, // digit 0 in low nibble
	output logic bad_digit // some digit is not bcd
);
	logic [NDIG-1:0] dig_bad;

	genvar gi;
	generate
		for (gi = 0; gi < NDIG; gi++) begin : g_dig
			// nibble >= 10 when bit3 and (bit2 or bit1)
			assign dig_bad[gi] = bcd_digit_fields[4*gi+3] &
				(bcd_digit_fields[4*gi+2] | bcd_digit_fields[4*gi+1]);
		end
	endgenerate

	assign bad_digit = |dig_bad;
endmodule

/* File: src/edc_classifier.sv */
// Purpose: classifies extended, decimal and integer operands; cleans containers
// Assumes: operand words arrive synchronous to ref_clk
// Notes: class is combinational inside, registered once at the outputs
// Operation
// - extended operand: fraction 0-62, j bit 63, exponent 64-78, sign 79
// - extended exponent is 15 bits with bias 16383
// - container bits above the operand ignored on input, zeroed on output
// - exponent not all ones and j set means normalized
// - exponent neither min nor max with j clear means unnormalized
// - zero exponent, j clear, nonzero fraction means denormalized
// - zero exponent with j set is normalized
// - max exponent, j plus fraction zero, is signed infinity
// - max exponent, nonzero j plus fraction is nan; bit 62 picks quiet
// - zero exponent and zero j plus fraction is signed zero
// - produced nans have j and fraction all ones, never trapping
// - decimal: 4-bit sign code low, 18 bcd digits, top digit most significant
// - sign code 0000 is plus infinity, 0001 minus infinity
// - sign code 0010 and 0011 are plus and minus quiet nan
// - sign codes 0100 to 1001 are trapping nan
// - sign code 10 or more with a non-bcd digit is quiet nan
// - valid sign codes: 1010,1100,1110,1111 positive; 1011,1101 negative
// - integer operands are 32-bit two's complement
`timescale 1ns/1ps
module edc_classifier
	import edc_pkg::*;
(
	input wire logic ref_clk, // 200 MHz clock
	input wire logic sys_rst, // synchronous reset, active high
	input wire edc_pkg::edc_fmt_t op_fmt, // format of the operand
	input wire logic [`EDC_CONT_W-1:0] op_word, // operand in 96-bit container
	input wire logic nan_gen, // replace an extended operand by a generated nan
	output edc_pkg::edc_cls_t cls_ff, // one-hot class, all zero for the reserved format
	output logic sign_ff, // operand is negative
	output logic [`EDC_EXT_EXP_W-1:0] exp_ff, // raw biased exponent
	output logic signed [15:0] unb_exp_ff, // exponent with bias removed
	output logic [`EDC_CONT_W-1:0] out_word_ff // cleaned container
);
	import edc_pkg::*;

	// ------------------------------------------------------------
	// extended field split
	// ------------------------------------------------------------
	logic ext_sign;
	logic [`EDC_EXT_EXP_W-1:0] ext_exp;
	logic ext_j;
	logic [`EDC_EXT_FRAC_MSB:0] ext_frac;
	logic exp_max;
	logic exp_min;
	logic jf_zero;

	assign ext_sign = op_word[`EDC_EXT_SIGN_BIT];
	assign ext_exp = op_word[`EDC_EXT_EXP_MSB:`EDC_EXT_EXP_LSB];
	assign ext_j = op_word[`EDC_EXT_J_BIT];
	assign ext_frac = op_word[`EDC_EXT_FRAC_MSB:0];
	assign exp_max = &ext_exp;
	assign exp_min = ~|ext_exp;
	assign jf_zero = ~ext_j & ~|ext_frac;

	// ------------------------------------------------------------
	// decimal field split
	// ------------------------------------------------------------
	logic [3:0] dec_code;
	logic [4*`EDC_DEC_DIGITS-1:0] bcd_digit_fields;
	logic dec_bad;

	assign dec_code = op_word[`EDC_DEC_SIGN_MSB:0];
	assign bcd_digit_fields = op_word[`EDC_DEC_W-1:`EDC_DEC_DIG_LSB];

	edc_dec_digit_chk #(
		.NDIG(`EDC_DEC_DIGITS)
	) u_dig (
		.bcd_digit_fields(bcd_digit_fields),
		.bad_digit(dec_bad)
	);

	// ------------------------------------------------------------
	// classification
	// ------------------------------------------------------------
	edc_cls_t nxt_cls;
	logic nxt_sign;
	logic [`EDC_EXT_EXP_W-1:0] nxt_exp;
	logic signed [15:0] nxt_unb_exp;
	logic [`EDC_CONT_W-1:0] nxt_out_word;

	always_comb begin
		nxt_cls = '0;
		nxt_sign = 1'b0;
		nxt_exp = '0;
		nxt_unb_exp = '0;
		nxt_out_word = '0;
		case (op_fmt)
			EDC_FMT_EXT: begin
				nxt_sign = ext_sign;
				nxt_exp = ext_exp;
				nxt_unb_exp = $signed({1'b0, ext_exp}) -
					$signed({1'b0, `EDC_EXT_BIAS});
				if (exp_max) begin
					if (jf_zero) begin
						nxt_cls[EDC_C_INF] = 1'b1;
					end else if (ext_frac[`EDC_EXT_FRAC_MSB]) begin
						nxt_cls[EDC_C_QNAN] = 1'b1;
					end else begin
						nxt_cls[EDC_C_SNAN] = 1'b1;
					end
				end else if (exp_min) begin
					if (jf_zero) begin
						nxt_cls[EDC_C_ZERO] = 1'b1;
					end else if (!ext_j) begin
						nxt_cls[EDC_C_DENORM] = 1'b1;
					end else begin
						nxt_cls[EDC_C_NORM] = 1'b1;
					end
				end else if (!ext_j) begin
					nxt_cls[EDC_C_UNNORM] = 1'b1;
				end else begin
					nxt_cls[EDC_C_NORM] = 1'b1;
				end
				// upper container bits dropped on the way out
				nxt_out_word[`EDC_EXT_W-1:0] = op_word[`EDC_EXT_W-1:0];
				if (nan_gen) begin
					// generated nan is always quiet: j and fraction all ones
					nxt_out_word[`EDC_EXT_EXP_MSB:0] = '1;
					nxt_cls = '0;
					nxt_cls[EDC_C_QNAN] = 1'b1;
				end
			end
			EDC_FMT_DEC: begin
				nxt_out_word[`EDC_DEC_W-1:0] = op_word[`EDC_DEC_W-1:0];
				case (dec_code)
					4'h0: begin
						nxt_cls[EDC_C_INF] = 1'b1;
					end
					4'h1: begin
						nxt_cls[EDC_C_INF] = 1'b1;
						nxt_sign = 1'b1;
					end
					4'h2: begin
						nxt_cls[EDC_C_QNAN] = 1'b1;
					end
					4'h3: begin
						nxt_cls[EDC_C_QNAN] = 1'b1;
						nxt_sign = 1'b1;
					end
					4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9: begin
						nxt_cls[EDC_C_SNAN] = 1'b1;
					end
					default: begin
						if (dec_bad) begin
							nxt_cls[EDC_C_QNAN] = 1'b1;
						end else begin
							nxt_cls[EDC_C_NUM] = 1'b1;
							nxt_sign = (dec_code == 4'hb) || (dec_code == 4'hd);
						end
					end
				endcase
			end
			EDC_FMT_INT: begin
				nxt_cls[EDC_C_NUM] = 1'b1;
				nxt_sign = op_word[`EDC_INT_W-1];
				nxt_out_word[`EDC_INT_W-1:0] = op_word[`EDC_INT_W-1:0];
			end
			default: begin
				nxt_cls = '0;
			end
		endcase
	end

	// ------------------------------------------------------------
	// output registers
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cls_ff <= '0;
			sign_ff <= 1'b0;
			exp_ff <= '0;
			unb_exp_ff <= '0;
			out_word_ff <= '0;
		end else begin
			cls_ff <= nxt_cls;
			sign_ff <= nxt_sign;
			exp_ff <= nxt_exp;
			unb_exp_ff <= nxt_unb_exp;
			out_word_ff <= nxt_out_word;
		end
	end
endmodule

/* File: verification/edc_monitor.sv */
// Purpose: port checker for edc_classifier
// Assumes: one cycle from inputs to registered outputs
// Notes: bound to the classifier below
`timescale 1ns/1ps
module edc_monitor
	import edc_pkg::*;
(
	input wire logic ref_clk, // clock
	input wire logic sys_rst, // reset
	input wire edc_pkg::edc_fmt_t op_fmt, // format
	input wire logic [95:0] op_word, // operand
	input wire logic nan_gen, // nan request
	input wire edc_pkg::edc_cls_t cls_ff, // class
	input wire logic sign_ff, // sign
	input wire logic [14:0] exp_ff, // exponent
	input wire logic signed [15:0] unb_exp_ff, // unbiased exponent
	input wire logic [95:0] out_word_ff // cleaned word
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	wire x = op_fmt == EDC_FMT_EXT && !nan_gen;
	wire [14:0] e = op_word[78:64];
	wire z = op_word[63:0] == 64'h0;
	chk_ext_inf: assert property (x && &e && z |=> cls_ff == 8'h10)
		else $error("ext infinity class wrong");
	chk_ext_nan: assert property (x && &e && !z |=> cls_ff == ($past(op_word[62]) ? 8'h20 : 8'h40))
		else $error("ext nan class wrong");
	chk_ext_norm: assert property (x && !(&e) && op_word[63] |=> cls_ff == 8'h01)
		else $error("ext normal class wrong");
	chk_ext_denorm: assert property (x && e == 0 && !op_word[63] && !z |=> cls_ff == 8'h04)
		else $error("ext denormal class wrong");
	chk_ext_zero: assert property (x && e == 0 && z |=> cls_ff == 8'h08 && sign_ff == $past(op_word[79]))
		else $error("ext zero wrong");
	chk_nan_fill: assert property (op_fmt == EDC_FMT_EXT && nan_gen |=> &out_word_ff[78:0] && cls_ff == 8'h20)
		else $error("generated nan wrong");
	chk_exp_bias: assert property (x |=> exp_ff == $past(e) && unb_exp_ff == $signed({1'b0, $past(e)}) - 16'sd16383)
		else $error("exponent bias wrong");
	chk_upper_zero: assert property (op_fmt != EDC_FMT_INT |=> out_word_ff[95:80] == 16'h0)
		else $error("upper container bits not zero");
	chk_dec_trap: assert property (op_fmt == EDC_FMT_DEC && op_word[3:0] inside {[4'h4:4'h9]} |=> cls_ff == 8'h40)
		else $error("decimal trapping nan wrong");
	cover property (x && &e && !z);
	cover property (op_fmt == EDC_FMT_DEC && op_word[3]);
	cover property (op_fmt == EDC_FMT_EXT && nan_gen);
endmodule
bind edc_classifier edc_monitor edc_monitor_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.op_fmt(op_fmt), .op_word(op_word), .nan_gen(nan_gen), .cls_ff(cls_ff), .sign_ff(sign_ff),
	.exp_ff(exp_ff), .unb_exp_ff(unb_exp_ff), .out_word_ff(out_word_ff));

/* File: verification/tb.sv */
// Purpose: self-checking bench for edc_classifier
// Assumes: one cycle latency, outputs zero after reset
// Notes: notes queued by the driver, compared at the falling edge
`timescale 1ns/1ps
module tb;
	import edc_pkg::*;
	logic ref_clk = 0, sys_rst = 1, nan_gen = 0, s, have = 0;
	edc_fmt_t op_fmt = EDC_FMT_EXT;
	logic [95:0] op_word = '0, out_word_ff;
	edc_cls_t cls_ff;
	logic [104:0] q[$], cur;
	logic [31:0] rs = 32'h54e0;
	int n_errors = 0, compares = 0, cyc = 0;
	always #2.5 ref_clk = ~ref_clk;
	edc_classifier edc_classifier_i (.ref_clk(ref_clk), .sys_rst(sys_rst), .op_fmt(op_fmt),
		.op_word(op_word), .nan_gen(nan_gen), .cls_ff(cls_ff), .sign_ff(s), .exp_ff(),
		.unb_exp_ff(), .out_word_ff(out_word_ff));
	function automatic logic [31:0] lfsr();
		rs = {rs[30:0], rs[31] ^ rs[21] ^ rs[1] ^ rs[0]};
		return rs;
	endfunction
	function automatic logic [95:0] xw(logic sg, logic [14:0] e, logic [63:0] jf);
		return {16'hffff, sg, e, jf};
	endfunction
	function automatic logic [104:0] model(edc_fmt_t f, logic [95:0] w, logic g);
		logic [7:0] c;
		logic sg;
		logic [95:0] o;
		logic bad;
		c = 0;
		sg = 0;
		o = 0;
		bad = 0;
		if (f == EDC_FMT_EXT) begin
			o = {16'h0, w[79:0]};
			sg = w[79];
			if (g) c = 8'h20;
			else if (&w[78:64]) c = w[63:0] == 0 ? 8'h10 : (w[62] ? 8'h20 : 8'h40);
			else if (w[63]) c = 8'h01;
			else if (w[78:64] != 0) c = 8'h02;
			else c = w[62:0] == 0 ? 8'h08 : 8'h04;
			if (g) o[78:0] = '1;
		end else if (f == EDC_FMT_DEC) begin
			o = {20'h0, w[75:0]};
			for (int i = 1; i < 19; i++) bad |= w[4*i+:4] > 4'h9;
			if (w[3:1] == 0) c = 8'h10;
			else if (w[3:1] == 1) c = 8'h20;
			else if (w[3:0] < 4'ha) c = 8'h40;
			else c = bad ? 8'h20 : 8'h80;
			sg = w[3:0] inside {4'h1, 4'h3, 4'hb, 4'hd} && !(w[3] && bad);
		end else if (f == EDC_FMT_INT) begin
			c = 8'h80;
			sg = w[31];
			o = {64'h0, w[31:0]};
		end
		return {c, sg, o};
	endfunction
	task end_of_test;
		$display("compares %0d mismatches %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(string nm, logic [95:0] e, logic [95:0] g);
		compares++;
		if (g !== e) begin
			n_errors++;
			$display("unexpected %s expected %h seen %h", nm, e, g);
		end
	endtask
	task drv(edc_fmt_t f, logic [95:0] w, logic g, logic r = 0);
		@(posedge ref_clk);
		sys_rst <= r;
		op_fmt <= f;
		op_word <= w;
		nan_gen <= g;
		q.push_back(r ? 105'h0 : model(f, w, g));
	endtask
	always @(negedge ref_clk) begin
		if (have) begin
			chk("class", 96'(cur[104:97]), 96'(cls_ff));
			chk("sign", 96'(cur[96]), 96'(s));
			chk("word", cur[95:0], out_word_ff);
		end
		have = q.size() > 0;
		if (have) cur = q.pop_front();
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			end_of_test;
		end
	end
	initial begin
		repeat (19) @(posedge ref_clk);
		drv(EDC_FMT_EXT, xw(1, '1, 64'h0), 0);
		drv(EDC_FMT_EXT, xw(0, '1, 64'h4000000000000000), 0);
		drv(EDC_FMT_EXT, xw(1, '1, 64'h8000000000000000), 0);
		drv(EDC_FMT_EXT, xw(0, 15'h7ffe, 64'h8000000000000000), 0);
		drv(EDC_FMT_EXT, xw(1, 15'h0001, 64'h1), 0);
		drv(EDC_FMT_EXT, xw(0, 15'h0, 64'h1), 0);
		drv(EDC_FMT_EXT, xw(1, 15'h0, 64'h8000000000000000), 1, 1);
		drv(EDC_FMT_EXT, xw(1, 15'h0, 64'h8000000000000000), 0);
		drv(EDC_FMT_EXT, xw(1, 15'h0, 64'h0), 0);
		drv(EDC_FMT_EXT, xw(1, 15'h1, 64'h5), 1);
		drv(EDC_FMT_INT, {64'hffffffffffffffff, 32'h80000000}, 1);
		drv(EDC_FMT_RSV, '1, 1);
		$display("test extended done");
		for (int c = 0; c < 16; c++) begin
			drv(EDC_FMT_DEC, {20'hfffff, 72'h987654321098765432, 4'(c)}, 1);
			drv(EDC_FMT_DEC, {20'h0, 4'ha, 68'h0, 4'(c)}, 0);
			drv(EDC_FMT_DEC, {20'h0, 68'h0, 4'hf, 4'(c)}, 0);
		end
		$display("test decimal done");
		repeat (400) drv(edc_fmt_t'(2'(lfsr())), {lfsr(), lfsr(), lfsr()}, 1'(lfsr()));
		$display("test random done");
		repeat (2) @(posedge ref_clk);
		end_of_test;
	end
endmodule
